// File: verilog/pmc_pkg.sv
// package of constants, types and register map for the privilege and mode control block
package pmc_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_MAIN_SP = 8'h08;
    localparam logic [7:0] ADDR_TASK_SP = 8'h0C;
    localparam logic [7:0] ADDR_EXEC_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_ACCESS = 8'h1C;
    localparam logic [7:0] ADDR_REGION = 8'h20;
    // ==========================================================
    // field positions
    localparam int CTRL_USER_BIT = 0;
    localparam int CTRL_ALT_STACK_BIT = 1;
    localparam int EXEC_COMPACT_BIT = 24;
    localparam int ACC_INSTR_BIT = 0;
    localparam int ACC_SPECIAL_BIT = 1;
    localparam int ACC_CONFIG_BIT = 2;
    localparam int ACC_DEBUG_BIT = 3;
    localparam int ACC_LEGACY_BIT = 4;
    localparam int EXC_ENTER_BIT = 8;
    localparam int EXC_RETURN_BIT = 9;
    localparam int EV_PRIV_FAULT = 0;
    localparam int EV_COMPACT_FAULT = 1;
    localparam int EV_DECODE_FAULT = 2;
    localparam int EV_EXC_ENTER = 3;
    localparam int EV_EXC_RETURN = 4;
    localparam int NUM_EVENTS = 5;
    // ==========================================================
    // reset values
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    localparam logic [31:0] SP_RESET = 32'h0000_0000;
    localparam logic [31:0] EXEC_STATUS_RESET = 32'h0100_0000;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    localparam logic [7:0] NEST_MAX = 8'hFF;
    // region decode: top address nibble
    localparam logic [3:0] REGION_CODE = 4'h0;
    localparam logic [3:0] REGION_SRAM = 4'h2;
    localparam logic [3:0] REGION_PERIPH = 4'h4;
    localparam logic [31:0] SRAM_BB_ALIAS = 32'h2200_0000;
    localparam logic [31:0] SRAM_BB_END = 32'h23FF_FFFF;
    // ==========================================================
    // types
    typedef enum logic [1:0] {PMC_REGION_CODE, PMC_REGION_DATA, PMC_REGION_PERIPH, PMC_REGION_OTHER} pmc_region_e;
    typedef enum {PMC_PRIV_THREAD, PMC_USER_THREAD, PMC_PRIV_HANDLER} pmc_mode_e;
    typedef struct packed {
        logic privileged;
        logic handler;
        logic task_stack;
    } pmc_state_s;
endpackage

// File: verilog/pmc_region_decode.sv
// address region decoder with bit-band alias translation
`timescale 1ns/1ps
`default_nettype none
module pmc_region_decode (
    input wire logic [31:0] addr,
    output pmc_pkg::pmc_region_e region,
    output logic bitband_hit,
    output logic [31:0] bitband_word,
    output logic [4:0] bitband_bit
);
    logic [24:0] offs;
    // full 4 GB space split on the top nibble into code, data, peripheral and other regions [RQ10]
    always_comb begin
        case (addr[31:28])
            pmc_pkg::REGION_CODE: region = pmc_pkg::PMC_REGION_CODE;
            pmc_pkg::REGION_SRAM: region = pmc_pkg::PMC_REGION_DATA;
            pmc_pkg::REGION_PERIPH: region = pmc_pkg::PMC_REGION_PERIPH;
            default: region = pmc_pkg::PMC_REGION_OTHER;
        endcase
    end
    // each alias word maps to one sram bit, so bit access is atomic [RQ7]
    always_comb begin
        offs = addr[24:0] - pmc_pkg::SRAM_BB_ALIAS[24:0];
        bitband_hit = (addr >= pmc_pkg::SRAM_BB_ALIAS) && (addr <= pmc_pkg::SRAM_BB_END);
        bitband_word = {12'h200, offs[24:7], 2'h0};
        bitband_bit = offs[6:2];
    end
endmodule
`default_nettype wire

// File: verilog/pmc_access_check.sv
// privilege and instruction-set access checker
`timescale 1ns/1ps
`default_nettype none
module pmc_access_check (
    input wire logic privileged,
    input wire logic [4:0] access_kind,
    input wire logic clear_compact,
    output logic priv_fault,
    output logic compact_fault,
    output logic decode_fault
);
    // user level blocks restricted instruction, special, config and debug access [RQ2]
    // privileged level lets all four restricted kinds through [RQ3]
    always_comb begin
        priv_fault = !privileged && (|access_kind[pmc_pkg::ACC_DEBUG_BIT:pmc_pkg::ACC_INSTR_BIT]);
        compact_fault = clear_compact; // compact state bit may never be cleared [RQ15]
        decode_fault = access_kind[pmc_pkg::ACC_LEGACY_BIT]; // legacy full-width set is not decoded [RQ6]
    end
endmodule
`default_nettype wire

// File: verilog/pmc_core_mode.sv
// privilege level, execution mode and stack selection controller with ahb-lite register slave
// ==========================================================
// Summary of operation
// [RQ1] handler mode exists only at privileged level; three legal states.
// [RQ2] user level blocks restricted instructions and registers and raises a fault.
// [RQ3] privileged level allows all instructions and registers without fault.
// [RQ4] servicing an exception means handler mode, forced privileged.
// [RQ5] no exception active means thread mode, privileged or user.
// [RQ6] only the compact 16/32-bit instruction set is decoded.
// [RQ7] sram bit-band alias gives atomic single-bit access.
// [RQ8] unaligned and mixed-length data accesses are supported.
// [RQ9] two stack pointers, main and task; one is active.
// [RQ10] 4 GB space decoded into code, data and peripheral regions.
// [RQ11] low external reset resets the device; pulled high when undriven.
// [RQ12] control bit 0: 0 privileged thread, 1 user thread.
// [RQ13] control bit 1 selects alternate stack; forced 0 in handler mode.
// [RQ14] task stack pointer used only at user level in thread mode.
// [RQ15] compact state bit always reads 1; clearing it faults.
// [RQ16] reset enters privileged thread mode using the main stack.
// [RQ17] last exception return restores prior level and stack selection.
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pmc_core_mode #(
    parameter int NEST_WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] data_addr,
    input wire logic [1:0] data_size,
    output logic [31:0] data_word_addr,
    output logic [1:0] data_region,
    output logic data_unaligned,
    output logic bitband_active,
    output logic [4:0] bitband_bit,
    output logic [31:0] active_stack_pointer,
    output logic privileged,
    output logic handler_mode,
    output logic fault_req,
    output logic irq
);
    // ==========================================================
    // elaboration checks
    // a wider nest counter gains nothing but area
    if (NEST_WIDTH < 1 || NEST_WIDTH > 8) begin : g_bad_nest
        $error("NEST_WIDTH must be 1 to 8");
    end

    // ==========================================================
    // bus address phase capture
    logic ap_valid_r, ap_valid_nxt;
    logic ap_write_r, ap_write_nxt;
    logic [7:0] ap_addr_r, ap_addr_nxt;

    // a transfer is taken when selected, nonseq or seq (htrans[1] set) and the bus is ready
    // hsize is ignored: whole words only
    always_comb begin
        ap_valid_nxt = hsel && htrans[1] && hready;
        ap_write_nxt = ap_write_r;
        ap_addr_nxt = ap_addr_r;

        if (hsel && htrans[1] && hready) begin
            ap_write_nxt = hwrite;
            ap_addr_nxt = haddr[7:0];
        end
    end

    // capture flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 8'h00;
        end else begin
            ap_valid_r <= ap_valid_nxt;
            ap_write_r <= ap_write_nxt;
            ap_addr_r <= ap_addr_nxt;
        end
    end

    // data-phase write strobe
    logic wr_en;
    assign wr_en = ap_valid_r && ap_write_r;

    // ==========================================================
    // access checks and region decode
    logic [4:0] access_kind;
    logic clear_compact;
    logic priv_fault, compact_fault, decode_fault;
    pmc_pkg::pmc_region_e region;
    logic bb_hit;
    logic [31:0] bb_word;
    logic [4:0] bb_bit;

    // mode and stack state
    logic [1:0] control_r, control_nxt;
    logic [NEST_WIDTH-1:0] nest_r, nest_nxt;
    logic [1:0] saved_control_r, saved_control_nxt;
    logic [31:0] main_sp_r, main_sp_nxt;
    logic [31:0] task_sp_r, task_sp_nxt;

    // interrupt state
    logic [4:0] irq_status_r, irq_status_nxt;
    logic [4:0] irq_mask_r, irq_mask_nxt;
    logic [4:0] events;
    logic exc_enter, exc_return, is_handler, is_priv;

    // software posts attempted accesses and exception entry/return through one strobe register
    assign access_kind = (wr_en && ap_addr_r == pmc_pkg::ADDR_ACCESS) ? hwdata[4:0] : 5'h00;
    assign exc_enter = wr_en && ap_addr_r == pmc_pkg::ADDR_ACCESS && hwdata[pmc_pkg::EXC_ENTER_BIT];
    assign exc_return = wr_en && ap_addr_r == pmc_pkg::ADDR_ACCESS && hwdata[pmc_pkg::EXC_RETURN_BIT]
        && (nest_r != '0);
    assign clear_compact = wr_en && ap_addr_r == pmc_pkg::ADDR_EXEC_STATUS
        && !hwdata[pmc_pkg::EXEC_COMPACT_BIT]; // [RQ15]

    // level and mode follow the nesting count
    assign is_handler = (nest_r != '0); // [RQ4] [RQ5]
    assign is_priv = is_handler || !control_r[pmc_pkg::CTRL_USER_BIT]; // handler forces privilege [RQ1] [RQ4]

    // fault class of each strobed access
    pmc_access_check u_check (
        .privileged(is_priv),
        .access_kind(access_kind),
        .clear_compact(clear_compact),
        .priv_fault(priv_fault),
        .compact_fault(compact_fault),
        .decode_fault(decode_fault)
    );

    // load/store address decode
    pmc_region_decode u_region (
        .addr(data_addr),
        .region(region),
        .bitband_hit(bb_hit),
        .bitband_word(bb_word),
        .bitband_bit(bb_bit)
    );

    // ==========================================================
    // mode, control and stack state
    // control register writes are privileged-only and ignored in handler for the stack bit
    always_comb begin
        control_nxt = control_r;
        nest_nxt = nest_r;
        saved_control_nxt = saved_control_r;
        main_sp_nxt = main_sp_r;
        task_sp_nxt = task_sp_r;
        if (wr_en && ap_addr_r == pmc_pkg::ADDR_CONTROL && is_priv) begin
            control_nxt[pmc_pkg::CTRL_USER_BIT] = hwdata[pmc_pkg::CTRL_USER_BIT]; // [RQ12]
            control_nxt[pmc_pkg::CTRL_ALT_STACK_BIT] = hwdata[pmc_pkg::CTRL_ALT_STACK_BIT] && !is_handler; // [RQ13]
        end

        // low two bits of each stack pointer are ignored, keeping word alignment [RQ9]
        if (wr_en && ap_addr_r == pmc_pkg::ADDR_MAIN_SP && is_priv) begin
            main_sp_nxt = {hwdata[31:2], 2'h0};
        end
        if (wr_en && ap_addr_r == pmc_pkg::ADDR_TASK_SP && is_priv) begin
            task_sp_nxt = {hwdata[31:2], 2'h0};
        end

        // first entry saves thread control; handler clears alternate stack bit [RQ4] [RQ13]
        if (exc_enter && nest_r != {NEST_WIDTH{1'b1}}) begin
            if (nest_r == '0) begin
                saved_control_nxt = control_r;
            end
            nest_nxt = nest_r + 1'b1;
            control_nxt[pmc_pkg::CTRL_ALT_STACK_BIT] = 1'b0;
        end else if (exc_return) begin
            nest_nxt = nest_r - 1'b1;
            if (nest_r == NEST_WIDTH'(1)) begin
                control_nxt = saved_control_r; // back to thread with prior state [RQ17]
            end
        end
    end

    // reset: privileged thread, main stack [RQ16] [RQ11]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_r <= pmc_pkg::CONTROL_RESET;
            nest_r <= '0;
            saved_control_r <= pmc_pkg::CONTROL_RESET;
            main_sp_r <= pmc_pkg::SP_RESET;
            task_sp_r <= pmc_pkg::SP_RESET;
        end else begin
            control_r <= control_nxt;
            nest_r <= nest_nxt;
            saved_control_r <= saved_control_nxt;
            main_sp_r <= main_sp_nxt;
            task_sp_r <= task_sp_nxt;
        end
    end

    // ==========================================================
    // interrupt status and mask
    // one event per status bit, lsb first
    assign events = {exc_return, exc_enter && nest_r != {NEST_WIDTH{1'b1}}, decode_fault, compact_fault,
        priv_fault};

    // set wins over a write-one clear in the same cycle
    always_comb begin
        irq_status_nxt = irq_status_r;
        irq_mask_nxt = irq_mask_r;

        if (wr_en && ap_addr_r == pmc_pkg::ADDR_IRQ_STATUS) begin
            irq_status_nxt = irq_status_r & ~hwdata[4:0];
        end
        if (wr_en && ap_addr_r == pmc_pkg::ADDR_IRQ_MASK) begin
            irq_mask_nxt = hwdata[4:0];
        end

        // events last, so a set beats a clear
        irq_status_nxt = irq_status_nxt | events;
    end

    // status and mask registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_r <= 5'h00;
            irq_mask_r <= pmc_pkg::IRQ_MASK_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // ==========================================================
    // outputs, all registered
    logic [31:0] rdata_nxt;
    logic [1:0] mode_bits;
    logic use_task_sp_nxt;

    // task stack only for user thread with alternate bit set [RQ14] [RQ9]
    assign use_task_sp_nxt = !(nest_nxt != '0) && control_nxt[pmc_pkg::CTRL_ALT_STACK_BIT]
        && control_nxt[pmc_pkg::CTRL_USER_BIT];
    assign mode_bits = {is_handler, is_priv};

    // read mux; unmapped offsets read zero with okay
    always_comb begin
        rdata_nxt = 32'h0000_0000;

        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                pmc_pkg::ADDR_CONTROL: rdata_nxt = {30'h0, control_nxt};
                pmc_pkg::ADDR_STATE: rdata_nxt = {29'h0, use_task_sp_nxt, mode_bits};
                pmc_pkg::ADDR_MAIN_SP: rdata_nxt = main_sp_nxt;
                pmc_pkg::ADDR_TASK_SP: rdata_nxt = task_sp_nxt;
                pmc_pkg::ADDR_EXEC_STATUS: rdata_nxt = pmc_pkg::EXEC_STATUS_RESET; // [RQ15]
                pmc_pkg::ADDR_IRQ_STATUS: rdata_nxt = {27'h0, irq_status_nxt};
                pmc_pkg::ADDR_IRQ_MASK: rdata_nxt = {27'h0, irq_mask_nxt};
                pmc_pkg::ADDR_REGION: rdata_nxt = {30'h0, region};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // hready and okay are constant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            data_word_addr <= 32'h0000_0000;
            data_region <= 2'h0;
            data_unaligned <= 1'b0;
            bitband_active <= 1'b0;
            bitband_bit <= 5'h00;
            active_stack_pointer <= pmc_pkg::SP_RESET;
            privileged <= 1'b1;
            handler_mode <= 1'b0;
            fault_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            hrdata <= rdata_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;

            // unaligned accesses pass through, flagged for the split logic [RQ8]
            data_word_addr <= bb_hit ? bb_word : {data_addr[31:2], 2'h0}; // [RQ7]
            data_region <= region; // [RQ10]
            data_unaligned <= (data_size == 2'h1 && data_addr[0]) || (data_size == 2'h2 && |data_addr[1:0]);
            bitband_active <= bb_hit;
            bitband_bit <= bb_bit;

            // mode outputs track the next state
            active_stack_pointer <= use_task_sp_nxt ? task_sp_nxt : main_sp_nxt; // [RQ14]
            privileged <= (nest_nxt != '0) || !control_nxt[pmc_pkg::CTRL_USER_BIT]; // [RQ1] [RQ3]
            handler_mode <= (nest_nxt != '0); // [RQ4]
            fault_req <= priv_fault || compact_fault || decode_fault; // [RQ2] [RQ6]
            irq <= |(irq_status_nxt & irq_mask_nxt);
        end
    end
endmodule
`default_nettype wire

// File: testbench/pmc_core_mode_monitor.sv
// concurrent checks on the mode, fault and address-path ports of the privilege and mode control block
`timescale 1ns/1ps
`default_nettype none
module pmc_core_mode_monitor #(
    parameter int NEST_WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] data_addr,
    input wire logic [1:0] data_size,
    input wire logic [31:0] data_word_addr,
    input wire logic [1:0] data_region,
    input wire logic data_unaligned,
    input wire logic bitband_active,
    input wire logic [4:0] bitband_bit,
    input wire logic privileged,
    input wire logic handler_mode,
    input wire logic fault_req
);
    // ==========================================================
    // helpers
    // address phase of a write to the access strobe register
    logic acc_wr;
    assign acc_wr = hsel && htrans[1] && hready && hwrite && (haddr == {24'h000000, pmc_pkg::ADDR_ACCESS});
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // assertions
    a_handler_only_priv: assert property (handler_mode |-> privileged)
        else $error("handler mode seen at user level");
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
    a_user_access_faults: assert property (acc_wr ##1 (!privileged && |hwdata[3:0]) |-> ##[1:2] fault_req)
        else $error("restricted access at user level gave no fault");
    a_priv_access_clean: assert property (acc_wr ##1 (privileged && |hwdata[3:0] && hwdata[9:4] == 6'h00)
        |-> ##1 !fault_req [*2])
        else $error("privileged access raised a fault");
    a_fault_one_cycle: assert property (fault_req |=> !fault_req)
        else $error("fault request longer than one cycle");
    a_enter_handler: assert property (acc_wr ##1 (hwdata[8] && !hwdata[9])
        |-> ##[1:2] (handler_mode && privileged))
        else $error("exception entry did not give privileged handler mode");
    a_reset_priv_thread: assert property ($rose(hresetn) |-> privileged && !handler_mode)
        else $error("reset did not leave privileged thread mode");
    a_region_sram: assert property (data_addr[31:28] == pmc_pkg::REGION_SRAM |=> data_region == 2'h1)
        else $error("sram address not decoded as data region");
    a_region_periph: assert property (data_addr[31:28] == pmc_pkg::REGION_PERIPH |=> data_region == 2'h2)
        else $error("peripheral address not decoded as peripheral region");
    a_bitband_map: assert property ((data_addr >= pmc_pkg::SRAM_BB_ALIAS && data_addr <= pmc_pkg::SRAM_BB_END)
        |=> bitband_active && bitband_bit == $past(data_addr[6:2])
        && data_word_addr == 32'h2000_0000 + {12'h000, $past(data_addr[24:7]), 2'h0})
        else $error("bit-band alias translated wrongly");
    a_word_unaligned: assert property ((data_size == 2'h2 && data_addr[1:0] != 2'h0) |=> data_unaligned)
        else $error("unaligned word access not flagged");
    a_byte_aligned: assert property (data_size == 2'h0 |=> !data_unaligned)
        else $error("byte access flagged as unaligned");
    // main scenarios reached
    c_enter: cover property (acc_wr ##1 hwdata[8]);
    c_user: cover property ($fell(privileged));
    c_fault: cover property ($rose(fault_req));
endmodule

bind pmc_core_mode pmc_core_mode_monitor #(.NEST_WIDTH(NEST_WIDTH)) u_monitor (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .data_addr(data_addr), .data_size(data_size),
    .data_word_addr(data_word_addr), .data_region(data_region), .data_unaligned(data_unaligned),
    .bitband_active(bitband_active), .bitband_bit(bitband_bit), .privileged(privileged),
    .handler_mode(handler_mode), .fault_req(fault_req));
`default_nettype wire

// File: testbench/pmc_core_mode_tb.sv
// self-checking bench for the privilege and mode control block
`timescale 1ns/1ps
`default_nettype none
module pmc_core_mode_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, data_addr, data_word_addr, active_stack_pointer, rd, a;
    logic [1:0] htrans, data_size, data_region, er;
    logic [2:0] hsize;
    logic [4:0] bitband_bit;
    logic data_unaligned, bitband_active, privileged, handler_mode, fault_req, irq, eu, eb;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int faults = 0;
    int f0;
    logic [31:0] av [6] = '{32'h0000_0102, 32'h2000_0001, 32'h2200_0084, 32'h23FF_FFFC, 32'h4000_0003, 32'hE000_0000};
    logic [1:0] sv [6] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0};

    pmc_core_mode #(.NEST_WIDTH(8)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .data_addr(data_addr), .data_size(data_size),
        .data_word_addr(data_word_addr), .data_region(data_region), .data_unaligned(data_unaligned),
        .bitband_active(bitband_active), .bitband_bit(bitband_bit), .active_stack_pointer(active_stack_pointer),
        .privileged(privileged), .handler_mode(handler_mode), .fault_req(fault_req), .irq(irq));

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    // ==========================================================
    // clock, fault pulse counter and hang guard
    initial begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (fault_req === 1'h1) begin
            faults <= faults + 1;
        end
        if (cycles == 4000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    // ==========================================================
    // tasks
    task automatic final_report();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; entered just after a rising edge, leaves on the edge ending the data phase
    task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        bus(1'h1, ad, d);
    endtask
    task automatic rdc(input logic [31:0] ad, input logic [31:0] exp);
        bus(1'h0, ad, 32'h0);
        chk(rd, exp);
    endtask
    // mode outputs land on the data-phase edge itself; the fault count moves one edge later
    task automatic settle();
        repeat (2) @(posedge hclk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        data_addr = 32'h0;
        data_size = 2'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rdc(pmc_pkg::ADDR_STATE, 32'h1);
        rdc(pmc_pkg::ADDR_EXEC_STATUS, 32'h0100_0000);
        rdc(32'h0000_0040, 32'h0);
        // stack pointers; the task pointer drops its two low bits
        wr(pmc_pkg::ADDR_MAIN_SP, 32'h2000_1000);
        wr(pmc_pkg::ADDR_TASK_SP, 32'h2000_0803);
        rdc(pmc_pkg::ADDR_TASK_SP, 32'h2000_0800);
        chk(active_stack_pointer, 32'h2000_1000);
        wr(pmc_pkg::ADDR_IRQ_MASK, 32'h1F);
        // every restricted kind at privileged level passes quietly
        for (int i = 0; i < 4; i++) wr(pmc_pkg::ADDR_ACCESS, 32'h1 << i);
        settle();
        chk(faults, 0);
        chk(irq, 1'h0);
        // legacy encoding and clearing the compact bit are both refused
        wr(pmc_pkg::ADDR_ACCESS, 32'h10);
        wr(pmc_pkg::ADDR_EXEC_STATUS, 32'h0);
        rdc(pmc_pkg::ADDR_EXEC_STATUS, 32'h0100_0000);
        rdc(pmc_pkg::ADDR_IRQ_STATUS, 32'h6);
        chk(irq, 1'h1);
        wr(pmc_pkg::ADDR_IRQ_MASK, 32'h0);
        settle();
        chk(irq, 1'h0);
        wr(pmc_pkg::ADDR_IRQ_STATUS, 32'h6);
        rdc(pmc_pkg::ADDR_IRQ_STATUS, 32'h0);
        wr(pmc_pkg::ADDR_IRQ_MASK, 32'h1F);
        // drop to user thread on the alternate stack
        wr(pmc_pkg::ADDR_CONTROL, 32'h3);
        settle();
        chk(privileged, 1'h0);
        chk(active_stack_pointer, 32'h2000_0800);
        rdc(pmc_pkg::ADDR_STATE, 32'h4);
        wr(pmc_pkg::ADDR_CONTROL, 32'h0);
        wr(pmc_pkg::ADDR_MAIN_SP, 32'h2000_2000);
        f0 = faults;
        for (int i = 0; i < 4; i++) wr(pmc_pkg::ADDR_ACCESS, 32'h1 << i);
        settle();
        chk(faults - f0, 4);
        rdc(pmc_pkg::ADDR_IRQ_STATUS, 32'h1);
        chk(irq, 1'h1);
        rdc(pmc_pkg::ADDR_CONTROL, 32'h3);
        rdc(pmc_pkg::ADDR_MAIN_SP, 32'h2000_1000);
        wr(pmc_pkg::ADDR_IRQ_STATUS, 32'h1F);
        // nested exceptions taken from user thread, then unwound
        wr(pmc_pkg::ADDR_ACCESS, 32'h100);
        settle();
        chk(handler_mode, 1'h1);
        chk(privileged, 1'h1);
        chk(active_stack_pointer, 32'h2000_1000);
        rdc(pmc_pkg::ADDR_STATE, 32'h3);
        wr(pmc_pkg::ADDR_CONTROL, 32'h2);
        bus(1'h0, pmc_pkg::ADDR_CONTROL, 32'h0);
        chk(rd & 32'h2, 32'h0);
        wr(pmc_pkg::ADDR_ACCESS, 32'h100);
        wr(pmc_pkg::ADDR_ACCESS, 32'h200);
        settle();
        chk(handler_mode, 1'h1);
        wr(pmc_pkg::ADDR_ACCESS, 32'h200);
        settle();
        rdc(pmc_pkg::ADDR_STATE, 32'h4);
        rdc(pmc_pkg::ADDR_CONTROL, 32'h3);
        chk(active_stack_pointer, 32'h2000_0800);
        // a return with nothing active changes nothing
        wr(pmc_pkg::ADDR_ACCESS, 32'h200);
        settle();
        rdc(pmc_pkg::ADDR_STATE, 32'h4);
        rdc(pmc_pkg::ADDR_IRQ_STATUS, 32'h18);
        // load/store address path over every region, alias boundary included
        for (int i = 0; i < 6; i++) begin
            data_addr <= av[i];
            data_size <= sv[i];
            settle();
            a = av[i];
            er = (a[31:28] == 4'h0) ? 2'h0 : (a[31:28] == 4'h2) ? 2'h1 : (a[31:28] == 4'h4) ? 2'h2 : 2'h3;
            eb = (a >= pmc_pkg::SRAM_BB_ALIAS) && (a <= pmc_pkg::SRAM_BB_END);
            eu = (sv[i] == 2'h2) ? (a[1:0] != 2'h0) : (sv[i] == 2'h1) ? a[0] : 1'h0;
            chk(data_region, er);
            chk(data_unaligned, eu);
            chk(bitband_active, eb);
            if (eb) begin
                chk(data_word_addr, 32'h2000_0000 + {a[24:7], 2'h0});
                chk(bitband_bit, a[6:2]);
            end else begin
                chk(data_word_addr, {a[31:2], 2'h0});
            end
            rdc(pmc_pkg::ADDR_REGION, er);
        end
        // reset again from user thread
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rdc(pmc_pkg::ADDR_STATE, 32'h1);
        rdc(pmc_pkg::ADDR_CONTROL, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
